//--- rtl/light_threshold_consts.svh
// Constants for the light threshold limit register bank.
// Assumes inclusion by the package; the design modules use its macros without including it.
`ifndef LIGHT_THRESHOLD_CONSTS_SVH
`define LIGHT_THRESHOLD_CONSTS_SVH

`define ADDR_LOWER_THRESHOLD  8'h02
`define ADDR_UPPER_THRESHOLD  8'h03
`define ADDR_MAKER_ID         8'h7e
`define EXP_MSB               15
`define EXP_LSB               12
`define MANT_MSB              11
`define LOWER_RESET           16'h0000
`define UPPER_RESET           16'hbfff
`define MAKER_CODE_DEFAULT    16'h4d4b
`define SCALED_WIDTH          27
`define FAULT_CODE_ONE        2'h0
`define FAULT_CODE_TWO        2'h1
`define FAULT_CODE_FOUR       2'h2
`define FAULT_CODE_EIGHT      2'h3
`define FAULT_NUM_ONE         4'h1
`define FAULT_NUM_TWO         4'h2
`define FAULT_NUM_FOUR        4'h4
`define FAULT_NUM_EIGHT       4'h8

`endif

//--- rtl/light_threshold_pkg.sv
// Types shared by the light threshold limit register bank.
// Assumes the constants header sits beside it.
`include "light_threshold_consts.svh"

package light_threshold_pkg;
  typedef logic [15:0]                  reg_word_type;
  typedef logic [`SCALED_WIDTH-1:0]     scaled_power_type;
  typedef enum logic [2:0] {
    CMP_INSIDE = 3'b001,
    CMP_BELOW  = 3'b010,
    CMP_ABOVE  = 3'b100
  } compare_state_type;
endpackage

//--- rtl/power_scaler.sv
// Converts an exponent and mantissa word to a common power integer.
// Assumes a 16-bit word with exponent on top; result in smallest steps.
`timescale 1ns/1ns

module power_scaler
  import light_threshold_pkg::*;
(
  input  wire reg_word_type     word,
  output scaled_power_type      scaled
);
  logic [3:0] expField;

  always_comb begin
    expField = word[`EXP_MSB:`EXP_LSB];
    // Mantissa shifted by the exponent; exact, so no rounding is lost.
    scaled = scaled_power_type'({15'h0000, word[`MANT_MSB:0]})
             << expField;
  end
endmodule

//--- rtl/light_threshold_limit_registers.sv
// Lower and upper threshold registers, maker identification and the
// consecutive-fault comparator that drives the limit flags.
// Assumes a register port decoded from the serial interface and a result
// word with a one-cycle valid pulse from the conversion engine.
//
// How it works
// - The lower threshold is read/write with exponent 15-12, mantissa 11-0.
// - The lower threshold sits at address 0x02 and is the lower bound.
// - A threshold means 1.2 nW/cm2 times two to the exponent times mantissa.
// - Exponent codes zero to eleven double the step from 1.2 upward.
// - Result and thresholds are compared as common power values.
// - Exponent masking never alters the value being compared.
// - The upper threshold is read/write at 0x03 and is the upper bound.
// - The upper threshold resets to 0xbfff.
// - Address 0x7e reads a fixed maker code and ignores writes.
// - The lower threshold resets to zero.
// - The below flag sets after the selected run of low results.
// - Fault count codes 00..11 select runs of one, two, four, eight.
`timescale 1ns/1ns

module light_threshold_limit_registers
  import light_threshold_pkg::*;
#(
  parameter logic [15:0] MAKER_CODE = `MAKER_CODE_DEFAULT
)
(
  input  wire logic         mclk,
  input  wire logic         srst,
  input  wire logic         clkEn,
  input  wire logic [7:0]   regAddr,
  input  wire logic         regWrite,
  input  wire logic         regRead,
  input  wire logic [15:0]  regWdata,
  output logic [15:0]       regRdata,
  output logic              regValid,
  input  wire logic [15:0]  resultWord,
  input  wire logic         resultValid,
  input  wire logic [1:0]   fault_count_select,
  input  wire logic         mask_result_exponent,
  output logic              above_limit_flag,
  output logic              below_limit_flag
);

  //////////////////////////////////////////////////////////////////////////
  // Register file.

  reg_word_type lower_reg;
  reg_word_type lower_next;
  reg_word_type upper_reg;
  reg_word_type upper_next;
  logic [15:0]  rdata_reg;
  logic [15:0]  rdata_next;
  logic         rvalid_reg;
  logic         rvalid_next;

  always_comb begin
    lower_next  = lower_reg;
    upper_next  = upper_reg;
    rdata_next  = rdata_reg;
    rvalid_next = 1'b0;
    if (regWrite) begin
      case (regAddr)
        `ADDR_LOWER_THRESHOLD: begin
          lower_next = regWdata;
        end
        `ADDR_UPPER_THRESHOLD: begin
          upper_next = regWdata;
        end
        default: begin
          // Writes to the identification word or elsewhere are dropped.
          lower_next = lower_reg;
        end
      endcase
    end
    if (regRead) begin
      rvalid_next = 1'b1;
      case (regAddr)
        `ADDR_LOWER_THRESHOLD: rdata_next = lower_reg;
        `ADDR_UPPER_THRESHOLD: rdata_next = upper_reg;
        `ADDR_MAKER_ID:        rdata_next = MAKER_CODE;
        default:               rdata_next = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      lower_reg  <= `LOWER_RESET;
      upper_reg  <= `UPPER_RESET;
      rdata_reg  <= 16'h0000;
      rvalid_reg <= 1'b0;
    end else if (clkEn) begin
      lower_reg  <= lower_next;
      upper_reg  <= upper_next;
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign regRdata = rdata_reg;
  assign regValid = rvalid_reg;

  //////////////////////////////////////////////////////////////////////////
  // Comparison on common power values.

  scaled_power_type resultPower;
  scaled_power_type lowerPower;
  scaled_power_type upperPower;

  // The raw result word is scaled; mask_result_exponent is not used by any logic.
  power_scaler resultScaler (
    .word   (resultWord),
    .scaled (resultPower)
  );
  power_scaler lowerScaler (
    .word   (lower_reg),
    .scaled (lowerPower)
  );
  power_scaler upperScaler (
    .word   (upper_reg),
    .scaled (upperPower)
  );

  logic isBelow;
  logic isAbove;
  logic maskUnused;

  assign isBelow    = resultPower < lowerPower;
  assign isAbove    = resultPower > upperPower;
  assign maskUnused = mask_result_exponent;

  //////////////////////////////////////////////////////////////////////////
  // Consecutive fault counting and flags.

  logic [3:0] faultTarget;

  always_comb begin
    case (fault_count_select)
      `FAULT_CODE_ONE:   faultTarget = `FAULT_NUM_ONE;
      `FAULT_CODE_TWO:   faultTarget = `FAULT_NUM_TWO;
      `FAULT_CODE_FOUR:  faultTarget = `FAULT_NUM_FOUR;
      `FAULT_CODE_EIGHT: faultTarget = `FAULT_NUM_EIGHT;
      default:           faultTarget = `FAULT_NUM_ONE;
    endcase
  end

  compare_state_type cmp_reg;
  compare_state_type cmp_next;
  logic [3:0]        run_reg;
  logic [3:0]        run_next;
  logic              above_reg;
  logic              above_next;
  logic              below_reg;
  logic              below_next;

  always_comb begin
    cmp_next   = cmp_reg;
    run_next   = run_reg;
    above_next = above_reg;
    below_next = below_reg;
    if (resultValid) begin
      case (cmp_reg)
        CMP_INSIDE, CMP_BELOW, CMP_ABOVE: begin
          if (isBelow) begin
            cmp_next = CMP_BELOW;
            run_next = (cmp_reg == CMP_BELOW && run_reg != faultTarget)
                       ? run_reg + 4'h1 : 4'h1;
            if (cmp_reg != CMP_BELOW) begin
              run_next = 4'h1;
            end
          end else if (isAbove) begin
            cmp_next = CMP_ABOVE;
            run_next = (cmp_reg == CMP_ABOVE && run_reg != faultTarget)
                       ? run_reg + 4'h1 : 4'h1;
            if (cmp_reg != CMP_ABOVE) begin
              run_next = 4'h1;
            end
          end else begin
            cmp_next = CMP_INSIDE;
            run_next = 4'h0;
          end
        end
        default: begin
          cmp_next = CMP_INSIDE;
          run_next = 4'h0;
        end
      endcase
      if (run_reg == faultTarget && cmp_next == cmp_reg) begin
        run_next = run_reg;
      end
      below_next = (cmp_next == CMP_BELOW)
                   && (run_next >= faultTarget);
      above_next = (cmp_next == CMP_ABOVE)
                   && (run_next >= faultTarget);
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      cmp_reg   <= CMP_INSIDE;
      run_reg   <= 4'h0;
      above_reg <= 1'b0;
      below_reg <= 1'b0;
    end else if (clkEn) begin
      cmp_reg   <= cmp_next;
      run_reg   <= run_next;
      above_reg <= above_next;
      below_reg <= below_next;
    end
  end

  assign above_limit_flag = above_reg;
  assign below_limit_flag = below_reg;

endmodule

//--- tb/light_threshold_chk.sv
// Port checker for the threshold register bank.
// Assumes it is bound to light_threshold_limit_registers.
`timescale 1ns/1ns
module light_threshold_chk
  import light_threshold_pkg::*;
#(parameter logic [15:0] MAKER_CODE = 16'h0000)
(
  input wire logic        mclk,
  input wire logic        srst,
  input wire logic        clkEn,
  input wire logic [7:0]  regAddr,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [15:0] regWdata,
  input wire logic [15:0] regRdata,
  input wire logic        regValid,
  input wire logic [15:0] resultWord,
  input wire logic        resultValid,
  input wire logic [1:0]  fault_count_select,
  input wire logic        mask_result_exponent,
  input wire logic        above_limit_flag,
  input wire logic        below_limit_flag
);
  reg_word_type lo_reg, hi_reg, lo_next, hi_next;
  function automatic scaled_power_type pw(reg_word_type w);
    return scaled_power_type'(w[11:0]) << w[15:12];
  endfunction
  // Shadows of both thresholds, fed from the write port.
  always_comb begin
    lo_next = lo_reg;
    hi_next = hi_reg;
    if (regWrite && clkEn && regAddr == 8'h02) lo_next = regWdata;
    if (regWrite && clkEn && regAddr == 8'h03) hi_next = regWdata;
  end
  always_ff @(posedge mclk) begin
    lo_reg <= srst ? 16'h0000 : lo_next;
    hi_reg <= srst ? 16'hbfff : hi_next;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  sequence rd_take;
    regRead && clkEn;
  endsequence
  sequence res_one;
    resultValid && clkEn && fault_count_select == 2'h0;
  endsequence
  chk_read_valid: assert property (rd_take |=> regValid)
    else $error("read not answered");
  chk_no_valid: assert property (clkEn && !regRead |=> !regValid)
    else $error("spurious read valid");
  chk_rdata_hold: assert property (!(regRead && clkEn) |=> $stable(regRdata))
    else $error("read data moved");
  chk_id_read: assert property (rd_take ##0 regAddr == 8'h7e
    |=> regRdata == MAKER_CODE) else $error("bad maker code");
  chk_unmapped_zero: assert property (rd_take ##0 !(regAddr inside
    {8'h02, 8'h03, 8'h7e}) |=> regRdata == 16'h0000)
    else $error("unmapped read not zero");
  chk_below_one: assert property (res_one ##0 pw(resultWord) < pw(lo_reg)
    |=> below_limit_flag) else $error("below flag missing");
  chk_above_one: assert property (res_one ##0 pw(resultWord) > pw(hi_reg)
    |=> above_limit_flag) else $error("above flag missing");
  chk_inside_clear: assert property (resultValid && clkEn
    && pw(resultWord) >= pw(lo_reg) && pw(resultWord) <= pw(hi_reg)
    |=> !above_limit_flag && !below_limit_flag)
    else $error("flag set inside window");
  chk_flag_hold: assert property (!(resultValid && clkEn)
    |=> $stable({above_limit_flag, below_limit_flag}))
    else $error("flags moved without result");
endmodule
bind light_threshold_limit_registers light_threshold_chk
  #(.MAKER_CODE(MAKER_CODE)) u_chk (.*);

//--- tb/host_model.sv
// Host side of the register port: one-cycle strobes.
// Assumes one caller at a time.
`timescale 1ns/1ns
module host_model (
  input  wire logic  mclk,
  output logic [7:0] regAddr,
  output logic       regWrite,
  output logic       regRead,
  output logic [15:0] regWdata
);
  initial begin
    regAddr = 8'h00;
    regWrite = 1'b0;
    regRead = 1'b0;
    regWdata = 16'h0000;
  end
  // Released address and data lines show inverted values so stale data is never trusted; strobes drop to zero.
  task automatic access(input logic [7:0] a, input logic w,
                        input logic [15:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWrite <= w;
    regRead <= !w;
    regWdata <= d;
    @(posedge mclk);
    regWrite <= 1'b0;
    regRead <= 1'b0;
    regAddr <= ~a;
    regWdata <= ~d;
  endtask
endmodule

//--- tb/testbench.sv
// Self-checking bench for the threshold register bank.
// Assumes host_model drives the register port.
`timescale 1ns/1ns
module testbench;
  import light_threshold_pkg::*;
  localparam logic [15:0] ID = 16'h5a3c; // Arbitrary maker code.
  logic mclk = 1'b0, srst = 1'b1, clkEn = 1'b1, resultValid = 1'b0;
  logic mask_result_exponent = 1'b0, due = 1'b0;
  logic [1:0] fault_count_select = 2'h0;
  logic [7:0] regAddr;
  logic regWrite, regRead, regValid, above_limit_flag, below_limit_flag;
  reg_word_type resultWord = 16'h0000, regRdata, regWdata, v;
  reg_word_type lo = 16'h3100, hi, rdQ[$];
  logic [1:0] flQ[$];
  int mismatches = 0, comparisons = 0, lowRun = 0, highRun = 0;
  host_model u_host (.*);
  light_threshold_limit_registers #(.MAKER_CODE(ID)) u_dut (.*);
  always #10 mclk = ~mclk;
  function automatic scaled_power_type pw(reg_word_type w);
    return scaled_power_type'(w[11:0]) << w[15:12];
  endfunction
  task automatic rd(input logic [7:0] a, input reg_word_type e);
    rdQ.push_back(e);
    u_host.access(a, 1'b0, 16'h0000);
  endtask
  task automatic res(input reg_word_type w);
    @(posedge mclk);
    lowRun = (pw(w) < pw(lo)) ? lowRun + 1 : 0;
    highRun = (pw(w) > pw(hi)) ? highRun + 1 : 0;
    flQ.push_back({highRun >= (1 << fault_count_select),
                   lowRun >= (1 << fault_count_select)});
    resultWord <= w;
    resultValid <= 1'b1;
    mask_result_exponent <= 1'($urandom);
    @(posedge mclk);
    resultValid <= 1'b0;
  endtask
  task automatic cmp_rd(input reg_word_type e);
    comparisons++;
    if (regRdata !== e) begin
      mismatches++;
      $display("wrong value regRdata expected %h seen %h", e, regRdata);
    end
  endtask
  task automatic cmp_fl(input logic [1:0] e);
    comparisons++;
    if ({above_limit_flag, below_limit_flag} !== e) begin
      mismatches++;
      $display("wrong value flags expected %b seen %b", e,
               {above_limit_flag, below_limit_flag});
    end
  endtask
  task automatic close_out;
    if (mismatches == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    if (regValid === 1'b1) cmp_rd(rdQ.pop_front());
    if (due) cmp_fl(flQ.pop_front());
    due <= resultValid;
  end
  ////////////////////////////////////////
  initial begin
    void'($urandom(88683));
    repeat (4) @(posedge mclk);
    srst <= 1'b0;
    rd(8'h02, 16'h0000);
    rd(8'h03, 16'hbfff);
    u_host.access(8'h7e, 1'b1, 16'h1234);
    rd(8'h7e, ID);
    rd(8'h40, 16'h0000);
    repeat (4) begin
      v = 16'($urandom);
      u_host.access(8'h02, 1'b1, v);
      rd(8'h02, v);
      u_host.access(8'h03, 1'b1, ~v);
      rd(8'h03, ~v);
    end
    repeat (2) @(posedge mclk);
    clkEn <= 1'b0;
    u_host.access(8'h02, 1'b1, 16'hffff);
    clkEn <= 1'b1;
    rd(8'h02, v);
    for (int p = 0; p < 2; p++) begin
      hi = p ? 16'h3800 : 16'h5100;
      u_host.access(8'h02, 1'b1, lo);
      u_host.access(8'h03, 1'b1, hi);
      for (int f = 0; f < 4; f++) begin
        fault_count_select <= 2'(f);
        res(16'h1400);
        repeat (9) res({5'h00, 11'($urandom)});
        res(hi);
        repeat (9) res({5'h17, 11'($urandom)});
      end
    end
    repeat (4) @(posedge mclk);
    close_out;
  end
  initial begin
    #100000;
    mismatches++;
    close_out;
  end
endmodule
